/* rtl/apc_aux_pin_controller.sv */
// Function
// - All pins are inputs after reset
// - Pins 0-2 I/O or channel straps by mode
// - Direction 1 input, sampled at read
// - Direction 0 drives output register bit
// - Drive bit 0 open-drain, 1 push-pull
// - Input register reads real pin level
// - Pin 5 select chooses clock output
// - Clock select: frame sync or bit clock
// - Pins 6,7 interrupt-capable, masked at reset
// - Input pins set status, mask gates interrupt
// - Per-pin edge or level trigger select
// - Pull-ups on pins 6,7 unless push-pull
// - Pin 7 select outputs stop/go bit
// - Pin 4 select dedicates multiframe bit
// - Multiframe output in terminal/trunk modes, else input
// - Straps form channel number, pin 2 MSB
// - Slow data clock allows channels 0-2
// - Channel number offsets timeslot selection
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module apc_aux_pin_controller
  import apc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [APC_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [APC_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [APC_NPIN-1:0] aux_in,
  output logic [APC_NPIN-1:0] aux_out,
  output logic [APC_NPIN-1:0] aux_oe,
  output logic [1:0] aux_pullup_en,
  input wire logic data_clock,
  input wire apc_mode_t op_mode,
  input wire logic stop_go_bit,
  input wire logic multiframe_tx,
  output logic multiframe_rx,
  output logic [2:0] channel_offset,
  output logic channel_error,
  output logic host_interrupt
);
  logic [APC_NPIN-1:0] in_s1_q;
  logic [APC_NPIN-1:0] in_s2_q;
  logic [1:0] int_prev_q;
  logic dck_s1_q;
  logic dck_s2_q;
  logic dck_prev_q;
  logic [7:0] dir_q;
  logic [7:0] out_q;
  logic [7:0] drv_q;
  apc_func_t fun_q;
  logic [1:0] imk_q;
  logic [1:0] ist_q;
  logic [1:0] ist_d;
  logic [1:0] int_ev;
  logic [1:0] ist_clr;
  logic bclk_q;
  logic fsync_q;
  logic [9:0] frm_cnt_q;
  logic dck_rise;
  logic [9:0] frm_last;
  logic awf_q;
  logic wf_q;
  logic [APC_AW-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_ok;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic rd_ok;
  logic [7:0] rd_byte;
  logic [APC_NPIN-1:0] oe_d;
  logic [APC_NPIN-1:0] o_d;
  logic chsel_mode;
  logic linecard;
  logic mf_out_mode;
  logic [2:0] strap;
  logic strap_bad;
  logic [1:0] pu_d;

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Idle high like the pulled-up pins, no false edge
      in_s1_q <= '1;
      in_s2_q <= '1;
      dck_s1_q <= 1'b0;
      dck_s2_q <= 1'b0;
    end else begin
      in_s1_q <= aux_in;
      in_s2_q <= in_s1_q;
      dck_s1_q <= data_clock;
      dck_s2_q <= dck_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_prev_q <= '1;
      dck_prev_q <= 1'b0;
    end else begin
      int_prev_q <= {in_s2_q[PIN_I1], in_s2_q[PIN_I0]};
      dck_prev_q <= dck_s2_q;
    end
  end

  // Mode decode
  always_comb begin
    chsel_mode = (op_mode == TRUNK_LINE_MODE) ||
                 (op_mode == SUBSCRIBER_LINE_MODE) ||
                 (op_mode == NETWORK_TERMINATION_MODE);
    linecard = (op_mode == TRUNK_LINE_MODE) ||
               (op_mode == SUBSCRIBER_LINE_MODE);
    mf_out_mode = (op_mode == TERMINAL_MODE) ||
                  (op_mode == TRUNK_LINE_MODE);
  end

  // Frame sync and bit clock from data clock
  assign dck_rise = dck_s2_q & ~dck_prev_q;
  assign frm_last = fun_q.data_clock_fast ? FRM_FAST_LAST : FRM_SLOW_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_cnt_q <= '0;
      bclk_q <= 1'b0;
      fsync_q <= 1'b0;
    end else if (dck_rise) begin
      bclk_q <= ~bclk_q;
      fsync_q <= (frm_cnt_q == '0);
      if (frm_cnt_q >= frm_last) begin
        frm_cnt_q <= '0;
      end else begin
        frm_cnt_q <= frm_cnt_q + 10'h001;
      end
    end
  end

  // AXI4-Lite handshakes
  assign aw_hs = s_axil_awvalid & s_axil_awready;
  assign w_hs = s_axil_wvalid & s_axil_wready;
  assign ar_hs = s_axil_arvalid & s_axil_arready;
  assign wr_fire = awf_q & wf_q & ~s_axil_bvalid;
  assign wr_ok = (awaddr_q[APC_AW-1:5] == '0) && (awaddr_q[1:0] == 2'h0);
  assign wsel = awaddr_q[4:2];
  assign rd_ok = (s_axil_araddr[APC_AW-1:5] == '0) && (s_axil_araddr[1:0] == 2'h0);
  assign rsel = s_axil_araddr[4:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awf_q <= 1'b0;
      s_axil_awready <= 1'b0;
      awaddr_q <= '0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axil_awaddr;
      end
      awf_q <= wr_fire ? 1'b0 : (awf_q | aw_hs);
      s_axil_awready <= ~(wr_fire ? 1'b0 : (awf_q | aw_hs));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wf_q <= 1'b0;
      s_axil_wready <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 1'b0;
    end else begin
      if (w_hs) begin
        wdata_q <= s_axil_wdata[7:0];
        wstrb_q <= s_axil_wstrb[0];
      end
      wf_q <= wr_fire ? 1'b0 : (wf_q | w_hs);
      s_axil_wready <= ~(wr_fire ? 1'b0 : (wf_q | w_hs));
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= DIR_RST;
      out_q <= OUT_RST;
      drv_q <= DRV_RST;
      fun_q <= FUN_RST;
      imk_q <= IMK_RST;
    end else if (wr_fire && wr_ok && wstrb_q) begin
      unique case (wsel)
        REG_DIR: dir_q <= wdata_q;
        REG_OUT: out_q <= wdata_q;
        REG_DRV: drv_q <= wdata_q;
        REG_FUN: fun_q <= wdata_q[6:0];
        REG_IMK: imk_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // Interrupt status, set wins over read clear
  generate
    for (genvar k = 0; k < 2; k++) begin : g_int
      localparam int P = PIN_I0 + k;
      logic armed;
      logic lvl;
      always_comb begin
        armed = dir_q[P] & ~(k == 1 && fun_q.pin7_function_select);
        lvl = (k == 0) ? fun_q.trig_level0 : fun_q.trig_level1;
      end
      assign int_ev[k] = armed & (lvl ? ~in_s2_q[P] : (int_prev_q[k] & ~in_s2_q[P]));
    end
  endgenerate

  // Status read clears both bits
  assign ist_clr = (ar_hs && rd_ok && rsel == REG_IST) ? 2'h3 : 2'h0;
  assign ist_d = (ist_q & ~ist_clr) | int_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= '0;
      host_interrupt <= 1'b0;
    end else begin
      ist_q <= ist_d;
      host_interrupt <= |(ist_q & ~imk_q);
    end
  end

  // Read path
  always_comb begin
    unique case (rsel)
      REG_DIR: rd_byte = dir_q;
      REG_OUT: rd_byte = out_q;
      REG_IN: rd_byte = in_s2_q;
      REG_DRV: rd_byte = drv_q;
      REG_FUN: rd_byte = {1'b0, fun_q};
      REG_IST: rd_byte = {6'h00, ist_q};
      REG_IMK: rd_byte = {6'h00, imk_q};
      REG_STA: rd_byte = {1'b0, op_mode, channel_error, channel_offset};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_arready <= 1'b0;
      s_axil_rdata <= '0;
      s_axil_rresp <= RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axil_rvalid <= 1'b1;
        s_axil_arready <= 1'b0;
        s_axil_rdata <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
        s_axil_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_rvalid) begin
        if (s_axil_rready) begin
          s_axil_rvalid <= 1'b0;
          s_axil_arready <= 1'b1;
        end
      end else begin
        s_axil_arready <= 1'b1;
      end
    end
  end

  // Per-pin drive
  generate
    for (genvar i = 0; i < APC_NPIN; i++) begin : g_pin
      logic oe;
      logic o;
      always_comb begin
        oe = ~dir_q[i] & (drv_q[i] | ~out_q[i]);
        o = drv_q[i] & out_q[i];
        if (i < NCH_PIN && chsel_mode) begin
          oe = 1'b0;
          o = 1'b0;
        end
        if (i == PIN_MF && fun_q.pin4_function_select) begin
          oe = mf_out_mode;
          o = mf_out_mode & multiframe_tx;
        end
        if (i == PIN_CK && fun_q.pin5_function_select) begin
          oe = 1'b1;
          o = fun_q.clock_output_select ? bclk_q : fsync_q;
        end
        if (i == PIN_I1 && fun_q.pin7_function_select) begin
          oe = 1'b1;
          o = stop_go_bit;
        end
      end
      assign oe_d[i] = oe;
      assign o_d[i] = o;
    end
  endgenerate

  // Pull-up enables
  always_comb begin
    pu_d[0] = dir_q[PIN_I0] | ~drv_q[PIN_I0];
    pu_d[1] = ~fun_q.pin7_function_select & (dir_q[PIN_I1] | ~drv_q[PIN_I1]);
  end

  // Pin output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_oe <= '0;
      aux_out <= '0;
      aux_pullup_en <= PU_RST;
    end else begin
      aux_oe <= oe_d;
      aux_out <= o_d;
      aux_pullup_en <= pu_d;
    end
  end

  // Multiframe input to transceiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiframe_rx <= 1'b0;
    end else begin
      multiframe_rx <= fun_q.pin4_function_select & ~mf_out_mode & in_s2_q[PIN_MF];
    end
  end

  // Channel select from straps
  assign strap = in_s2_q[NCH_PIN-1:0];
  assign strap_bad = ~fun_q.data_clock_fast & (strap > CH_MAX_SLOW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_offset <= '0;
      channel_error <= 1'b0;
    end else begin
      channel_offset <= (linecard && !strap_bad) ? strap : 3'h0;
      channel_error <= linecard & strap_bad;
    end
  end
endmodule
`default_nettype wire

/* rtl/apc_pkg.sv */
`default_nettype none
package apc_pkg;
  localparam int APC_NPIN = 8;
  localparam int APC_AW = 8;
  localparam int PIN_MF = 4;
  localparam int PIN_CK = 5;
  localparam int PIN_I0 = 6;
  localparam int PIN_I1 = 7;
  localparam int NCH_PIN = 3;
  localparam logic [2:0] REG_DIR = 3'h0;
  localparam logic [2:0] REG_OUT = 3'h1;
  localparam logic [2:0] REG_IN = 3'h2;
  localparam logic [2:0] REG_DRV = 3'h3;
  localparam logic [2:0] REG_FUN = 3'h4;
  localparam logic [2:0] REG_IST = 3'h5;
  localparam logic [2:0] REG_IMK = 3'h6;
  localparam logic [2:0] REG_STA = 3'h7;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] DRV_RST = 8'h00;
  localparam logic [6:0] FUN_RST = 7'h00;
  localparam logic [1:0] IMK_RST = 2'h3;
  localparam logic [1:0] PU_RST = 2'h3;
  localparam logic [2:0] CH_MAX_SLOW = 3'h2;
  localparam logic [9:0] FRM_SLOW_LAST = 10'h0BF;
  localparam logic [9:0] FRM_FAST_LAST = 10'h1FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    TERMINAL_MODE = 3'h0,
    TRUNK_LINE_MODE = 3'h1,
    SUBSCRIBER_LINE_MODE = 3'h2,
    NETWORK_TERMINATION_MODE = 3'h3,
    INTELLIGENT_NETWORK_TERMINATION_MODE = 3'h4
  } apc_mode_t;
  typedef struct packed {
    logic data_clock_fast;
    logic trig_level1;
    logic trig_level0;
    logic pin4_function_select;
    logic pin7_function_select;
    logic clock_output_select;
    logic pin5_function_select;
  } apc_func_t;
endpackage
`default_nettype wire

/* tb/apc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_chk
  import apc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic [APC_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic [APC_NPIN-1:0] aux_out,
  input wire logic [APC_NPIN-1:0] aux_oe,
  input wire logic [1:0] aux_pullup_en,
  input wire apc_mode_t op_mode,
  input wire logic multiframe_rx,
  input wire logic [2:0] channel_offset,
  input wire logic channel_error
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic addr_bad;
  assign addr_bad = s_axil_araddr[7:5] != 3'h0 || s_axil_araddr[1:0] != 2'h0;
  sequence s_wtake;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready && !s_axil_bvalid;
  endsequence
  sequence s_rtake;
    s_axil_arvalid && s_axil_arready;
  endsequence
  sequence s_term;
    op_mode == TERMINAL_MODE && $past(op_mode) == TERMINAL_MODE;
  endsequence
  AST_RST_INPUT: assert property ($rose(aresetn) |-> aux_oe == 8'h00 [*3])
    else $error("pin driven after reset");
  AST_WR_RESP: assert property (s_wtake |-> ##2 s_axil_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_rtake |=> s_axil_rvalid)
    else $error("read data late");
  AST_RD_BAD: assert property (s_rtake ##0 addr_bad |=> s_axil_rresp == RESP_SLVERR && s_axil_rdata == 32'h0)
    else $error("bad address not refused");
  AST_RD_OK: assert property (s_rtake ##0 !addr_bad |=> s_axil_rresp == RESP_OKAY && s_axil_rdata[31:8] == 24'h0)
    else $error("good read refused");
  AST_PULL6: assert property (aux_oe[PIN_I0] && aux_out[PIN_I0] |-> !aux_pullup_en[0])
    else $error("pin6 pull-up on in push-pull");
  AST_PULL7: assert property (aux_oe[PIN_I1] && aux_out[PIN_I1] |-> !aux_pullup_en[1])
    else $error("pin7 pull-up on in push-pull");
  AST_CH_ERR: assert property (channel_error |-> channel_offset == 3'h0)
    else $error("bad channel passed on");
  AST_CH_TERM: assert property (s_term |-> channel_offset == 3'h0 && !channel_error)
    else $error("channel used in terminal mode");
  AST_MF_TERM: assert property (s_term |-> !multiframe_rx)
    else $error("multiframe input in terminal mode");
endmodule
`default_nettype wire

/* tb/apc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_board (
  input wire logic aclk,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [1:0] pu_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  logic tog = 1'b0;
  always @(posedge aclk) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_oe[i]) pin[i] = drv_out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (i >= 6 && pu_en[i[0]]) pin[i] = 1'b1;
      else pin[i] = tog;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_aux_pin_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_aux_pin_controller
  import apc_pkg::*;
  ;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, ext_val = 8'hFF, ext_en = 8'hFF;
  logic [31:0] wd = 32'h0;
  logic awr, wr, bv, arr, rv, mfr, cherr, hint, stopgo = 1'b0, mft = 1'b0;
  logic [1:0] bresp, rresp, pu, dcn = 2'h0, bres = 2'h0;
  logic [31:0] rdata;
  logic [7:0] pin, aux_out, aux_oe;
  logic [2:0] choff;
  apc_mode_t op_mode = TERMINAL_MODE;
  int n_errors = 0, n_checks = 0;
  logic [7:0] rst_a [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [7:0] rst_v [6] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  always #2 aclk = ~aclk;
  always @(posedge aclk) dcn <= dcn + 2'h1;
  apc_aux_pin_controller dut (
    .aclk, .aresetn, .s_axil_awaddr(awa), .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_wdata(wd),
    .s_axil_wstrb(4'hF), .s_axil_wvalid(wv), .s_axil_wready(wr), .s_axil_bresp(bresp), .s_axil_bvalid(bv),
    .s_axil_bready(br), .s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rv), .s_axil_rready(rr), .aux_in(pin), .aux_out, .aux_oe,
    .aux_pullup_en(pu), .data_clock(dcn[1]), .op_mode, .stop_go_bit(stopgo), .multiframe_tx(mft),
    .multiframe_rx(mfr), .channel_offset(choff), .channel_error(cherr), .host_interrupt(hint)
  );
  apc_board brd (.aclk, .drv_out(aux_out), .drv_oe(aux_oe), .pu_en(pu), .ext_val, .ext_en, .pin);
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    $display("[ERR] %0t timeout", $time);
    summarize;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("[ERR] %0t count %0d", $time, n);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'b0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!hb && n < 200) begin
      @(negedge aclk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      if (bv) bres = bresp;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) br <= 1'b0;
      n++;
    end
    if (!hb) tmo;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    logic ha, hb;
    n = 0;
    hb = 1'b0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!hb && n < 200) begin
      @(negedge aclk);
      ha = arv && arr;
      hb = rv;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
      if (hb) rr <= 1'b0;
      n++;
    end
    if (!hb) tmo;
    @(posedge aclk);
  endtask
  task automatic cnt5(input int k, output int n);
    logic p;
    n = 0;
    p = 1'b1;
    repeat (k) begin
      @(negedge aclk);
      if (aux_out[PIN_CK] && !p) n++;
      p = aux_out[PIN_CK];
    end
    @(posedge aclk);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      axr(rst_a[i], d, r);
      chk(d, rst_v[i]);
    end
    chk(aux_oe, 8'h00);
    chk({6'h0, pu}, 8'h03);
    axr(8'h20, d, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    axw(8'h21, 8'h5A);
    chk({6'h0, bres}, {6'h0, RESP_SLVERR});
    axr(8'h00, d, r);
    chk(d, 8'hFF);
  endtask
  task automatic t_gpio;
    logic [7:0] d;
    logic [1:0] r;
    ext_val <= 8'h00;
    axw(8'h04, 8'hC5);
    axw(8'h0C, 8'hFF);
    axw(8'h00, 8'h00);
    chk(aux_oe, 8'hFF);
    chk(aux_out, 8'hC5);
    chk({6'h0, pu}, 8'h00);
    chk({6'h0, bres}, {6'h0, RESP_OKAY});
    cyc(2);
    axr(8'h08, d, r);
    chk(d, 8'hC5);
    axw(8'h0C, 8'h00);
    chk(aux_oe, 8'h3A);
    chk({6'h0, pu}, 8'h03);
    cyc(2);
    axr(8'h08, d, r);
    chk(d, 8'h00);
    axw(8'h00, 8'hFF);
    ext_val <= 8'h3C;
    cyc(4);
    chk(aux_oe, 8'h00);
    axr(8'h08, d, r);
    chk(d, 8'h3C);
  endtask
  task automatic t_alt;
    axw(8'h04, 8'h00);
    axw(8'h00, 8'h00);
    axw(8'h10, 8'h0C);
    stopgo <= 1'b1;
    cyc(3);
    chk(aux_oe, 8'hFF);
    chk(aux_out & 8'h90, 8'h80);
    stopgo <= 1'b0;
    mft <= 1'b1;
    cyc(3);
    chk(aux_out & 8'h90, 8'h10);
    op_mode <= NETWORK_TERMINATION_MODE;
    ext_val <= 8'h10;
    cyc(5);
    chk(aux_oe, 8'hE8);
    chk({7'h0, mfr}, 8'h01);
    ext_val <= 8'h00;
    cyc(5);
    chk({7'h0, mfr}, 8'h00);
    op_mode <= TERMINAL_MODE;
  endtask
  task automatic t_clk;
    int n;
    axw(8'h10, 8'h03);
    cnt5(800, n);
    rng(n, 99, 101);
    chk(aux_oe & 8'h20, 8'h20);
    axw(8'h10, 8'h01);
    cnt5(1600, n);
    rng(n, 2, 3);
    axw(8'h10, 8'h00);
    cnt5(100, n);
    rng(n, 0, 0);
  endtask
  task automatic t_irq;
    logic [7:0] d;
    logic [1:0] r;
    ext_en <= 8'h3F;
    axw(8'h00, 8'hFF);
    cyc(5);
    axr(8'h14, d, r);
    axw(8'h18, 8'h02);
    ext_en <= 8'hFF;
    ext_val <= 8'hBF;
    cyc(6);
    chk({7'h0, hint}, 8'h01);
    axr(8'h14, d, r);
    chk(d, 8'h01);
    axr(8'h14, d, r);
    chk(d, 8'h00);
    chk({7'h0, hint}, 8'h00);
    axw(8'h10, 8'h10);
    axr(8'h14, d, r);
    axr(8'h14, d, r);
    chk(d, 8'h01);
    ext_val <= 8'hFF;
    axw(8'h10, 8'h00);
    cyc(5);
    axr(8'h14, d, r);
    ext_val <= 8'h7F;
    cyc(6);
    chk({7'h0, hint}, 8'h00);
    axr(8'h14, d, r);
    chk(d, 8'h02);
  endtask
  task automatic t_chan;
    logic [7:0] d;
    logic [1:0] r;
    logic ln;
    axw(8'h00, 8'h00);
    axw(8'h10, 8'h48);
    ext_val <= 8'hF5;
    for (int m = 0; m < 5; m++) begin
      op_mode <= apc_mode_t'(m);
      cyc(5);
      ln = m == 1 || m == 2;
      chk({5'h0, choff}, ln ? 8'h05 : 8'h00);
      chk(aux_oe & 8'h17, {3'h0, m < 2, 1'b0, ln || m == 3 ? 3'h0 : 3'h7});
    end
    op_mode <= TRUNK_LINE_MODE;
    cyc(5);
    axr(8'h1C, d, r);
    chk(d, 8'h15);
    axw(8'h10, 8'h08);
    cyc(5);
    chk({7'h0, cherr}, 8'h01);
    axr(8'h1C, d, r);
    chk(d, 8'h18);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_gpio;
    t_alt;
    t_clk;
    t_irq;
    t_chan;
    summarize;
  end
endmodule
bind apc_aux_pin_controller apc_chk chk (
  .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid,
  .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rvalid, .s_axil_rdata, .s_axil_rresp,
  .aux_out, .aux_oe, .aux_pullup_en, .op_mode, .multiframe_rx, .channel_offset, .channel_error
);
`default_nettype wire
